// *** pkg/lcd_drive_params.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the lcd drive block
// Assumes: 32-bit aligned register words on the bus
// Notes: included by bare name
`ifndef LCD_DRIVE_PARAMS_SVH
`define LCD_DRIVE_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_PUMP 8'h04
`define OFS_STAT 8'h08
`define OFS_MEM_BASE 8'h40
`define MEM_WORDS 24

// ----------------------------------------
// control word fields
// ----------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_BIAS_LSB 1
`define CTRL_TYPE_BIT 7
`define CTRL_RESET 8'h00

// ----------------------------------------
// pump word fields
// ----------------------------------------
`define PUMP_PVS_LSB 0
`define PUMP_SUPPLY_BIT 3
`define PUMP_DUTY_BIT 4
`define PUMP_RESET 8'h00

// ----------------------------------------
// status word fields
// ----------------------------------------
`define STAT_DISP_RST_BIT 0
`define STAT_FLOAT_BIT 1
`define STAT_PHASE_BIT 2
`define STAT_SLOT_LSB 4
`define STAT_SLEEP_BIT 8

// ----------------------------------------
// timing
// ----------------------------------------
`define SUB_CLOCK_DIVIDE 8
`define FLOAT_HOLD_CYCLES 16

`endif

// *** pkg/lcd_drive_pkg.sv ***
// Purpose: types shared by the lcd drive block
// Assumes: nothing
// Notes: constants live in lcd_drive_params.svh
package lcd_drive_pkg;

  // drive level of a common or segment line, 1/3 bias
  typedef enum logic [1:0] {
    LVL_VSS = 2'b00,
    LVL_VC = 2'b01,
    LVL_VB = 2'b10,
    LVL_VA = 2'b11
  } level_t;

  // charge pump output level
  typedef enum logic [2:0] {
    PUMP_3V3 = 3'b000,
    PUMP_3V0 = 3'b001,
    PUMP_2V7 = 3'b010,
    PUMP_4V5 = 3'b011,
    PUMP_4V3 = 3'b100,
    PUMP_4V0 = 3'b101
  } pump_level_t;

  // register decode result
  typedef enum logic [2:0] {
    K_CTRL = 3'b000,
    K_PUMP = 3'b001,
    K_STAT = 3'b010,
    K_MEM = 3'b011,
    K_NONE = 3'b100
  } reg_kind_t;

endpackage

// *** hdl/lcd_pixel_store.sv ***
// Purpose: display memory, one word of common bits per segment line
// Assumes: single clock, contents undefined at power-on
// Notes: both read ports are registered
`timescale 1ns/10ps
module lcd_pixel_store #(
  parameter int SEGS = 24,
  parameter int COMS = 6
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [COMS-1:0] wr_data,
  // bus read port
  input wire logic [4:0] rd_addr,
  output logic [COMS-1:0] rd_data,
  // column read port
  input wire logic [2:0] col_sel,
  output logic [SEGS-1:0] col_bits
);

  logic [COMS-1:0] mem [SEGS];

  if (SEGS > 32 || COMS > 8)
  begin : g_chk
    $error("lcd_pixel_store: size out of range");
  end

  always_ff @(posedge clk)
  begin
    if (wr_en && (int'(wr_addr) < SEGS))
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    rd_data <= (int'(rd_addr) < SEGS) ? mem[rd_addr] : '0;
  end

  // one bit per segment for the active common line
  always_ff @(posedge clk)
  begin
    for (int s = 0; s < SEGS; s++)
    begin
      col_bits[s] <= (int'(col_sel) < COMS) ? mem[s][col_sel] : 1'b0;
    end
  end

endmodule

// *** hdl/lcd_drive_control.sv ***
// Purpose: segment lcd drive control with axi4-lite registers
// Assumes: aclk 20 MHz, sub_clock is a slow asynchronous pin
// Notes: line levels are codes for the analog bias switches
//
// Summary of operation
// - supply select 0 takes panel power from the pin, pump code ignored.
// - pump codes 000, 110, 111 give 3.3V.
// - pump codes 010, 011, 101 give 2.7V, 4.5V, 4.0V.
// - lines use four levels: ground, full, two thirds, one third.
// - bias network current path off while display disabled.
// - display reset is not-enable OR sleep.
// - sleep resets display even with enable set.
// - device reset floats all lines for the reset duration plus FLOAT_HOLD cycles.
// - outside device reset, lines low when disabled or sleeping.
// - watchdog reset in idle or sleep does not float lines.
// - duty sets common line count and slots per frame.
// - two waveform types; second type has lower frequency.
// - waveforms keep net dc across every pixel at zero.
// - enable zero drives all lines to ground, blank display.
// - enable resets to zero at power-on.
// - display clock is sub clock divided by 8.
// - duty bit 0 gives four commons, 1 gives six.
// - pump codes 001 and 100 give 3.0V and 4.3V.
// - memory bit 1 turns pixel on; writes show at once.
`timescale 1ns/10ps
`include "lcd_drive_params.svh"
module lcd_drive_control #(
  parameter int SEG_LINES = 24,
  parameter int COM_LINES = 6,
  parameter int FLOAT_HOLD = `FLOAT_HOLD_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // system pins
  input wire logic sub_clock,
  input wire logic sleep_mode,
  input wire logic device_reset,
  input wire logic wdt_low_power_reset,
  // panel lines
  output logic [2*COM_LINES-1:0] com_level,
  output logic [2*SEG_LINES-1:0] seg_level,
  output logic drive_oe,
  // analog controls
  output logic bias_path_on,
  output logic [1:0] bias_current_select,
  output logic pump_enable,
  output lcd_drive_pkg::pump_level_t pump_level,
  output logic panel_from_pin
);

  if (SEG_LINES != `MEM_WORDS || COM_LINES != 6 || FLOAT_HOLD < 1 || FLOAT_HOLD > 255)
  begin : g_chk
    $error("lcd_drive_control: unsupported parameters");
  end

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic lcd_drive_pkg::reg_kind_t decode(input logic [7:0] a);
    logic [7:0] top;
    top = 8'(`OFS_MEM_BASE + 4 * `MEM_WORDS);
    if (a[1:0] != 2'h0) return lcd_drive_pkg::K_NONE;
    if (a == `OFS_CTRL) return lcd_drive_pkg::K_CTRL;
    if (a == `OFS_PUMP) return lcd_drive_pkg::K_PUMP;
    if (a == `OFS_STAT) return lcd_drive_pkg::K_STAT;
    if (a >= `OFS_MEM_BASE && a < top) return lcd_drive_pkg::K_MEM;
    return lcd_drive_pkg::K_NONE;
  endfunction

  function automatic logic [4:0] mem_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFS_MEM_BASE;
    return d[6:2];
  endfunction

  function automatic lcd_drive_pkg::pump_level_t pump_decode(input logic [2:0] c);
    case (c)
      3'h1: return lcd_drive_pkg::PUMP_3V0;
      3'h2: return lcd_drive_pkg::PUMP_2V7;
      3'h3: return lcd_drive_pkg::PUMP_4V5;
      3'h4: return lcd_drive_pkg::PUMP_4V3;
      3'h5: return lcd_drive_pkg::PUMP_4V0;
      default: return lcd_drive_pkg::PUMP_3V3;
    endcase
  endfunction

  // selected common full swing, others one third from the rail
  function automatic lcd_drive_pkg::level_t com_drive(input logic sel, input logic ph);
    if (sel) return ph ? lcd_drive_pkg::LVL_VSS : lcd_drive_pkg::LVL_VA;
    return ph ? lcd_drive_pkg::LVL_VB : lcd_drive_pkg::LVL_VC;
  endfunction

  // on pixel sits opposite the selected common, off pixel at one third
  function automatic lcd_drive_pkg::level_t seg_drive(input logic on, input logic ph);
    if (on) return ph ? lcd_drive_pkg::LVL_VA : lcd_drive_pkg::LVL_VSS;
    return ph ? lcd_drive_pkg::LVL_VC : lcd_drive_pkg::LVL_VB;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic sub_prev;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      sub_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= {wdt_low_power_reset, device_reset, sleep_mode, sub_clock};
      pin_sync <= pin_meta;
      sub_prev <= pin_sync[0];
    end
  end

  logic sleep_s;
  logic mcu_rst;
  assign sleep_s = pin_sync[1];
  assign mcu_rst = pin_sync[2] && !pin_sync[3];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic enable;
  logic type_b;
  logic duty6;
  logic supply_source_select;
  logic [2:0] pump_voltage_select;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] wstrb_q;
  logic commit;
  lcd_drive_pkg::reg_kind_t wr_kind;

  assign commit = !awready && !wready && !bvalid;
  assign wr_kind = decode(aw_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || mcu_rst)
    begin
      enable <= 1'b0;
      type_b <= 1'b0;
      bias_current_select <= 2'h0;
      duty6 <= 1'b0;
      supply_source_select <= 1'b0;
      pump_voltage_select <= 3'h0;
    end
    else if (commit && wstrb_q[0])
    begin
      if (wr_kind == lcd_drive_pkg::K_CTRL)
      begin
        enable <= w_q[`CTRL_ENABLE_BIT];
        type_b <= w_q[`CTRL_TYPE_BIT];
        bias_current_select <= w_q[`CTRL_BIAS_LSB +: 2];
      end
      if (wr_kind == lcd_drive_pkg::K_PUMP)
      begin
        duty6 <= w_q[`PUMP_DUTY_BIT];
        supply_source_select <= w_q[`PUMP_SUPPLY_BIT];
        pump_voltage_select <= w_q[`PUMP_PVS_LSB +: 3];
      end
    end
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_q <= wdata;
        wstrb_q <= wstrb;
        wready <= 1'b0;
      end
      if (commit)
      begin
        bvalid <= 1'b1;
        bresp <= (wr_kind == lcd_drive_pkg::K_NONE) ? 2'h2 : 2'h0;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  logic rd_pend;
  lcd_drive_pkg::reg_kind_t rd_kind;
  logic [COM_LINES-1:0] mem_rd;
  logic [SEG_LINES-1:0] column;
  logic disp_rst;
  logic floating;
  logic phase;
  logic [2:0] slot;
  logic [31:0] stat_word;

  always_comb
  begin
    stat_word = 32'h0;
    stat_word[`STAT_DISP_RST_BIT] = disp_rst;
    stat_word[`STAT_FLOAT_BIT] = floating;
    stat_word[`STAT_PHASE_BIT] = phase;
    stat_word[`STAT_SLOT_LSB +: 3] = slot;
    stat_word[`STAT_SLEEP_BIT] = sleep_s;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rd_pend <= 1'b0;
      rd_kind <= lcd_drive_pkg::K_NONE;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end
    else
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rd_pend <= 1'b1;
        rd_kind <= decode(araddr);
      end
      if (rd_pend)
      begin
        rd_pend <= 1'b0;
        rvalid <= 1'b1;
        rresp <= (rd_kind == lcd_drive_pkg::K_NONE) ? 2'h2 : 2'h0;
        case (rd_kind)
          lcd_drive_pkg::K_CTRL: rdata <= {24'h0, type_b, 4'h0, bias_current_select, enable};
          lcd_drive_pkg::K_PUMP: rdata <= {27'h0, duty6, supply_source_select,
                                           pump_voltage_select};
          lcd_drive_pkg::K_STAT: rdata <= stat_word;
          lcd_drive_pkg::K_MEM: rdata <= {26'h0, mem_rd[5:4] & {2{duty6}}, mem_rd[3:0]};
          default: rdata <= 32'h0;
        endcase
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // display memory
  // ----------------------------------------
  lcd_pixel_store #(
    .SEGS(SEG_LINES),
    .COMS(COM_LINES)
  ) u_store (
    .clk(aclk),
    .wr_en(commit && wstrb_q[0] && wr_kind == lcd_drive_pkg::K_MEM),
    .wr_addr(mem_index(aw_q)),
    .wr_data(w_q[COM_LINES-1:0]),
    .rd_addr(mem_index(araddr)),
    .rd_data(mem_rd),
    .col_sel(slot),
    .col_bits(column)
  );

  // ----------------------------------------
  // reset and float control
  // ----------------------------------------
  logic [7:0] float_cnt;

  assign disp_rst = !enable || sleep_s;
  assign floating = mcu_rst || float_cnt != 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      float_cnt <= 8'h00;
    else if (mcu_rst)
      float_cnt <= 8'(FLOAT_HOLD);
    else if (float_cnt != 8'h00)
      float_cnt <= float_cnt - 8'h01;
  end

  // ----------------------------------------
  // display clock and slot sequencing
  // ----------------------------------------
  logic [2:0] div_cnt;
  logic sub_rise;
  logic tick;
  logic [2:0] slot_max;

  assign sub_rise = pin_sync[0] && !sub_prev;
  assign tick = sub_rise && div_cnt == 3'(`SUB_CLOCK_DIVIDE - 1);
  assign slot_max = duty6 ? 3'h5 : 3'h3;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_cnt <= 3'h0;
    else if (sub_rise)
      div_cnt <= div_cnt + 3'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || disp_rst)
    begin
      slot <= 3'h0;
      phase <= 1'b0;
    end
    else if (slot > slot_max)
    begin
      // duty shrank under a running frame: wrap now, as a type b wrap would
      slot <= 3'h0;
      phase <= !phase;
    end
    else if (tick)
    begin
      if (type_b)
      begin
        if (slot >= slot_max)
        begin
          slot <= 3'h0;
          phase <= !phase;
        end
        else
          slot <= slot + 3'h1;
      end
      else if (!phase)
        phase <= 1'b1;
      else
      begin
        phase <= 1'b0;
        slot <= (slot >= slot_max) ? 3'h0 : slot + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // line levels
  // ----------------------------------------
  logic [2:0] slot_q;
  logic phase_q;
  logic [2*COM_LINES-1:0] next_com;
  logic [2*SEG_LINES-1:0] next_seg;

  always_comb
  begin
    next_com = '0;
    next_seg = '0;
    if (!disp_rst)
    begin
      for (int c = 0; c < COM_LINES; c++)
      begin
        if (c <= int'(slot_max))
          next_com[2*c +: 2] = com_drive(3'(c) == slot_q, phase_q);
      end
      for (int s = 0; s < SEG_LINES; s++)
      begin
        if (!duty6 || s < SEG_LINES - 2)
          next_seg[2*s +: 2] = seg_drive(column[s], phase_q);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slot_q <= 3'h0;
      phase_q <= 1'b0;
      com_level <= '0;
      seg_level <= '0;
      drive_oe <= 1'b0;
      bias_path_on <= 1'b0;
    end
    else
    begin
      slot_q <= slot;
      phase_q <= phase;
      com_level <= next_com;
      seg_level <= next_seg;
      drive_oe <= !floating;
      bias_path_on <= !disp_rst;
    end
  end

  // ----------------------------------------
  // supply selection
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pump_enable <= 1'b0;
      panel_from_pin <= 1'b1;
      pump_level <= lcd_drive_pkg::PUMP_3V3;
    end
    else
    begin
      pump_enable <= supply_source_select;
      panel_from_pin <= !supply_source_select;
      pump_level <= pump_decode(pump_voltage_select);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_pin_supply;
    @(posedge aclk) disable iff (!aresetn) !supply_source_select |=> panel_from_pin && !pump_enable;
  endproperty
  a_pin_supply: assert property (p_pin_supply) else $error("pin supply not selected");

  property p_pump_default;
    @(posedge aclk) disable iff (!aresetn)
      (pump_voltage_select inside {3'h0, 3'h6, 3'h7}) |=> pump_level == lcd_drive_pkg::PUMP_3V3;
  endproperty
  a_pump_default: assert property (p_pump_default) else $error("pump not 3.3V");

  property p_pump_mid;
    @(posedge aclk) disable iff (!aresetn)
      (pump_voltage_select == 3'h3) |=> pump_level == lcd_drive_pkg::PUMP_4V5;
  endproperty
  a_pump_mid: assert property (p_pump_mid) else $error("pump not 4.5V");

  property p_pump_low;
    @(posedge aclk) disable iff (!aresetn)
      (pump_voltage_select == 3'h1) |=> pump_level == lcd_drive_pkg::PUMP_3V0;
  endproperty
  a_pump_low: assert property (p_pump_low) else $error("pump not 3.0V");

  property p_bias_off;
    @(posedge aclk) disable iff (!aresetn) !enable |=> !bias_path_on;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias path on while disabled");

  property p_sleep_low;
    @(posedge aclk) disable iff (!aresetn)
      sleep_s && !floating |=> drive_oe && com_level == '0 && seg_level == '0;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("lines not low in sleep");

  property p_float;
    @(posedge aclk) disable iff (!aresetn) mcu_rst |=> !drive_oe [*2];
  endproperty
  a_float: assert property (p_float) else $error("lines driven in device reset");

  property p_wdt_excluded;
    @(posedge aclk) disable iff (!aresetn)
      pin_sync[3] && float_cnt == 8'h00 |=> drive_oe;
  endproperty
  a_wdt_excluded: assert property (p_wdt_excluded) else $error("watchdog floated lines");

  property p_slot_range;
    @(posedge aclk) disable iff (!aresetn)
      slot <= 3'h5 && (duty6 || slot <= 3'h3 || $changed(duty6));
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("slot out of duty range");

  property p_hold_start;
    @(posedge aclk) disable iff (!aresetn) disp_rst |=> slot == 3'h0 && !phase;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("slot ran in display reset");

  property p_type_b_flip;
    @(posedge aclk) disable iff (!aresetn)
      tick && type_b && !disp_rst && slot >= slot_max ##1 !disp_rst |-> phase != $past(phase);
  endproperty
  a_type_b_flip: assert property (p_type_b_flip) else $error("frame polarity not flipped");

endmodule

// *** tb/lcd_glass.sv ***
// Purpose: passive segment panel, integrates the voltage across each pixel
// Assumes: level code n stands for n thirds of the panel supply
// Notes: window opens at the first common change after arm and lasts LEN cycles
`timescale 1ns/10ps
module lcd_glass #(
  parameter int COMS = 6,
  parameter int SEGS = 24,
  parameter int LEN = 1536
) (
  // clock and control
  input wire logic aclk,
  input wire logic arm,
  // panel lines
  input wire logic [2*COMS-1:0] com_level,
  input wire logic [2*SEGS-1:0] seg_level,
  input wire logic drive_oe,
  // window over
  output logic done
);
  int dc[COMS][SEGS];
  int sq[COMS][SEGS];
  int flips;
  int cnt;
  int d;
  logic [2*COMS-1:0] prev;

  // ----------------------------------------
  // pixel integration
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!arm)
    begin
      cnt = 0;
      flips = 0;
      dc = '{default: 0};
      sq = '{default: 0};
    end
    else if (cnt < LEN && drive_oe && (cnt > 0 || com_level != prev))
    begin
      if (cnt > 0 && com_level[1:0] != prev[1:0])
        flips++;
      cnt++;
      for (int c = 0; c < COMS; c++)
        for (int s = 0; s < SEGS; s++)
        begin
          d = int'(com_level[2*c+:2]) - int'(seg_level[2*s+:2]);
          dc[c][s] += d;
          sq[c][s] += d * d;
        end
    end
    done <= (cnt == LEN);
    prev <= com_level;
  end
endmodule

// *** tb/tb_segment_lcd_drive_control.sv ***
// Purpose: self-checking bench of the segment lcd drive control
// Assumes: display tick every 64 aclk cycles, float hold shortened to 4
// Notes: registers over axi4-lite, panel modelled by lcd_glass
`timescale 1ns/10ps
`include "lcd_drive_params.svh"
module tb_segment_lcd_drive_control;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 0;
  logic bready = 0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 0;
  logic rready = 0;
  logic sub_clock = 0;
  logic sleep_mode = 0;
  logic device_reset = 0;
  logic wdt_low_power_reset = 0;
  logic arm = 0;
  logic [2:0] sub_div = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, drive_oe, bias_path_on;
  logic pump_enable, panel_from_pin, done;
  logic [1:0] bresp, rresp, bias_current_select, r;
  logic [31:0] rdata, q;
  logic [11:0] com_level;
  logic [47:0] seg_level;
  lcd_drive_pkg::pump_level_t pump_level;
  logic [31:0] seed = 32'h3b3c;
  int errors = 0;
  int compares = 0;
  int mem[24];
  int fa, fb;

  lcd_drive_control #(.FLOAT_HOLD(4)) i_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .sub_clock, .sleep_mode, .device_reset, .wdt_low_power_reset, .com_level,
    .seg_level, .drive_oe, .bias_path_on, .bias_current_select, .pump_enable,
    .pump_level, .panel_from_pin
  );
  lcd_glass #(.LEN(1536)) i_glass (.aclk, .arm, .com_level, .seg_level, .drive_oe, .done);

  initial forever #25 aclk = ~aclk;

  // sub clock of 8 aclk cycles
  always @(posedge aclk)
  begin
    sub_div <= sub_div + 3'h1;
    sub_clock <= sub_div[2];
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic hang();
    errors++;
    end_of_test();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic quiet();
    return ({com_level, seg_level} === 60'h0);
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    if (w)
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
    end
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 0;
      if (wvalid && wready)
        wvalid <= 0;
      if (arvalid && arready)
        arvalid <= 0;
    end while (!(w ? bvalid : rvalid) && n < 100);
    if (n >= 100)
      hang();
    r = w ? bresp : rresp;
    q = rdata;
    bready <= 0;
    rready <= 0;
  endtask

  task automatic glass(input int duty, output int flips);
    int n;
    n = 0;
    repeat (200) @(posedge aclk);
    arm <= 1;
    while (done !== 1 && n < 4000)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= 4000)
      hang();
    for (int c = 0; c < duty; c++)
      for (int s = 0; s < (duty == 6 ? 22 : 24); s++)
      begin
        check(i_glass.dc[c][s], 0);
        check(i_glass.sq[c][s], 64 * (24 + (mem[s][c] ? 192 / duty : 0)));
      end
    flips = i_glass.flips;
    arm <= 0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    bus(0, `OFS_CTRL, 0);
    check(q, 0);
    repeat (6) @(posedge aclk);
    check(quiet(), 1);
    check(bias_path_on, 0);
    bus(0, 8'h0c, 0);
    check(r, 2'h2);
    check(q, 0);
    bus(1, 8'h0c, 32'h1);
    check(r, 2'h2);
    for (int i = 0; i < 16; i++)
    begin
      bus(1, `OFS_PUMP, i);
      repeat (2) @(posedge aclk);
      check(panel_from_pin, !i[3]);
      check(pump_enable, i[3]);
      if (i[3])
        check(pump_level, (i[2:0] > 5) ? 0 : i[2:0]);
    end
    bus(1, `OFS_PUMP, 32'h10);
    for (int s = 0; s < `MEM_WORDS; s++)
    begin
      mem[s] = rnd() & 32'h3f;
      bus(1, 8'(`OFS_MEM_BASE + 4 * s), mem[s]);
    end
    for (int k = 1; k >= 0; k--)
    begin
      bus(1, `OFS_PUMP, k << 4);
      for (int s = 0; s < `MEM_WORDS; s++)
      begin
        bus(0, 8'(`OFS_MEM_BASE + 4 * s), 0);
        check(q, mem[s] & (k ? 32'h3f : 32'hf));
      end
    end
    bus(1, `OFS_CTRL, 32'h5);
    repeat (2) @(posedge aclk);
    check(bias_current_select, 2'h2);
    check(bias_path_on, 1);
    glass(4, fa);
    check(fa, 23);
    bus(1, `OFS_PUMP, 32'h10);
    bus(1, `OFS_CTRL, 32'h81);
    glass(6, fb);
    check(fb < fa, 1);
    sleep_mode <= 1;
    repeat (6) @(posedge aclk);
    check(quiet(), 1);
    check(drive_oe, 1);
    bus(0, `OFS_STAT, 0);
    check(q, (1 << `STAT_DISP_RST_BIT) | (1 << `STAT_SLEEP_BIT));
    sleep_mode <= 0;
    // two sync edges, then slot and level registers: before any tick lands
    repeat (4) @(posedge aclk);
    check(com_level[1:0], 2'h3);
    bus(1, `OFS_CTRL, 32'h80);
    repeat (3) @(posedge aclk);
    check(quiet(), 1);
    check(bias_path_on, 0);
    for (int w = 1; w >= 0; w--)
    begin
      bus(1, `OFS_CTRL, 32'h1);
      wdt_low_power_reset <= w[0];
      device_reset <= 1;
      repeat (8) @(posedge aclk);
      check(drive_oe, w[0]);
      device_reset <= 0;
      repeat (2) @(posedge aclk);
      check(drive_oe, w[0]);
      repeat (12) @(posedge aclk);
      check(drive_oe, 1);
      bus(0, `OFS_CTRL, 0);
      check(q, w[0]);
    end
    end_of_test();
  end
endmodule
